// >>> pvic_ctrl.sv
// prioritized vectored interrupt controller with apb registers
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module pvic_ctrl #(
   parameter int NUM_SLOT = 17
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [7:0] periph_pulse_in,
   input wire logic [7:0] port_a_pin_in,
   input wire logic [3:0] port_c_pin_in,
   input wire logic wdt_timeout_in,
   input wire logic wdt_irq_enable_in,
   input wire logic posc_fail_in,
   input wire logic wosc_fail_in,
   input wire logic illegal_instr_in,
   input wire pvic_pkg::pvic_core_t core_in,
   output logic irq_req_out,
   output logic [15:0] vector_addr_out,
   output logic [4:0] vector_slot_out,
   output logic global_irq_enable_bit_out
);
   // peripheral pulses: 7 timer1, 6 timer0, 5 rx, 4 tx, 3 adc,
   // 2 low_voltage_detector, 1 comparator, 0 unused spare
   logic [1:0] pa_sync_r [8];
   logic [1:0] pc_sync_r [4];
   logic [7:0] pa_prev_r;
   logic [3:0] pc_prev_r;
   logic [1:0] wdt_sync_r;
   logic [NUM_SLOT-1:0] pend_r;
   logic [NUM_SLOT-1:0] enab_r;
   logic [2*NUM_SLOT-1:0] prio_r;
   logic [7:0] edge_sel_r;
   logic global_irq_enable_bit_r;
   logic [NUM_SLOT-1:0] hw_set;
   logic [7:0] pa_now;
   logic [3:0] pc_now;
   logic [7:0] pa_evt;
   logic [3:0] pc_evt;
   logic wdt_req;
   logic trap_any;
   logic win_valid;
   logic [4:0] win_slot;
   logic [15:0] win_vec;
   logic apb_wr;
   logic apb_rd;
   logic [31:0] rd_data;
   logic bad_addr;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_pa
         // pins are asynchronous to clk_in: two flops before any edge logic
         always_ff @(posedge clk_in)
         begin
            if (rst_in)
            begin
               pa_sync_r[gi] <= 2'h0;
            end
            else
            begin
               pa_sync_r[gi] <= {pa_sync_r[gi][0], port_a_pin_in[gi]};
            end
         end
         assign pa_now[gi] = pa_sync_r[gi][1];
         // selectable edge: 1 rising, 0 falling
         assign pa_evt[gi] = edge_sel_r[gi] ? (pa_now[gi] & ~pa_prev_r[gi])
                                           : (~pa_now[gi] & pa_prev_r[gi]);
      end
      for (gi = 0; gi < 4; gi++)
      begin : g_pc
         always_ff @(posedge clk_in)
         begin
            if (rst_in)
            begin
               pc_sync_r[gi] <= 2'h0;
            end
            else
            begin
               pc_sync_r[gi] <= {pc_sync_r[gi][0], port_c_pin_in[gi]};
            end
         end
         assign pc_now[gi] = pc_sync_r[gi][1];
         // no edge select here: port c always reports both edges
         assign pc_evt[gi] = pc_now[gi] ^ pc_prev_r[gi];
      end
   endgenerate

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         pa_prev_r <= 8'h00;
         pc_prev_r <= 4'h0;
         wdt_sync_r <= 2'h0;
      end
      else
      begin
         pa_prev_r <= pa_now;
         pc_prev_r <= pc_now;
         // watchdog lives on a slower clock, so resynchronise its level
         wdt_sync_r <= {wdt_sync_r[0], wdt_timeout_in};
      end
   end

   assign wdt_req = wdt_sync_r[1] & wdt_irq_enable_in;
   assign trap_any = posc_fail_in | wosc_fail_in | illegal_instr_in | core_in.trap;

   // slot map: 0..3 timer1,timer0,rx,tx; 4 adc; 5 pa7/lvd; 6 pa6/comp;
   // 7..12 pa5..pa0; 13..16 pc3..pc0
   always_comb
   begin
      hw_set = '0;
      hw_set[0] = periph_pulse_in[7];
      hw_set[1] = periph_pulse_in[6];
      hw_set[2] = periph_pulse_in[5];
      hw_set[3] = periph_pulse_in[4];
      hw_set[4] = periph_pulse_in[3];
      hw_set[5] = pa_evt[7] | periph_pulse_in[2];
      hw_set[6] = pa_evt[6] | periph_pulse_in[1];
      for (int i = 0; i < 6; i++)
      begin
         hw_set[7+i] = pa_evt[5-i];
      end
      for (int i = 0; i < 4; i++)
      begin
         hw_set[13+i] = pc_evt[3-i];
      end
   end

   // writes land only on the edge that completes the transfer
   assign apb_wr = psel_in & penable_in & pwrite_in & pready_out;
   assign apb_rd = psel_in & penable_in & ~pwrite_in;
   always_comb
   begin
      bad_addr = 1'b0;
      rd_data = 32'h0000_0000;
      if (paddr_in == pvic_pkg::OFS_PEND)
      begin
         rd_data[NUM_SLOT-1:0] = pend_r;
      end
      else if (paddr_in == pvic_pkg::OFS_ENAB)
      begin
         rd_data[NUM_SLOT-1:0] = enab_r;
      end
      else if (paddr_in == pvic_pkg::OFS_PRIO)
      begin
         rd_data = prio_r[31:0];
      end
      else if (paddr_in == pvic_pkg::OFS_PRIO + 8'h20)
      begin
         rd_data[2*NUM_SLOT-33:0] = prio_r[2*NUM_SLOT-1:32];
      end
      else if (paddr_in == pvic_pkg::OFS_CTRL)
      begin
         rd_data[pvic_pkg::CTRL_GIE_BIT] = global_irq_enable_bit_r;
      end
      else if (paddr_in == pvic_pkg::OFS_EDGE)
      begin
         rd_data[7:0] = edge_sel_r;
      end
      else if (paddr_in == pvic_pkg::OFS_STAT)
      begin
         rd_data = {10'h000, win_valid, win_slot, win_vec};
      end
      else
      begin
         // unmapped: error answer, read zero, write dropped
         bad_addr = 1'b1;
      end
   end

   // pending bits: hardware set wins over a clearing write or ack
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         pend_r <= pvic_pkg::PEND_RST[NUM_SLOT-1:0];
      else
      begin
         for (int i = 0; i < NUM_SLOT; i++)
         begin
            if (hw_set[i])
            begin
               pend_r[i] <= 1'b1;
            end
            else if (apb_wr && paddr_in == pvic_pkg::OFS_PEND)
            begin
               pend_r[i] <= pwdata_in[i];
            end
            else if (core_in.ack && irq_req_out && vector_slot_out == 5'(i))
            begin
               pend_r[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         enab_r <= pvic_pkg::ENAB_RST[NUM_SLOT-1:0];
         prio_r <= pvic_pkg::PRIO_RST[2*NUM_SLOT-1:0];
         edge_sel_r <= pvic_pkg::EDGE_RST;
      end
      else if (apb_wr)
      begin
         if (paddr_in == pvic_pkg::OFS_ENAB)
         begin
            enab_r <= pwdata_in[NUM_SLOT-1:0];
         end
         else if (paddr_in == pvic_pkg::OFS_PRIO)
         begin
            prio_r[31:0] <= pwdata_in;
         end
         else if (paddr_in == pvic_pkg::OFS_PRIO + 8'h20)
         begin
            prio_r[2*NUM_SLOT-1:32] <= pwdata_in[2*NUM_SLOT-33:0];
         end
         else if (paddr_in == pvic_pkg::OFS_EDGE)
         begin
            edge_sel_r <= pwdata_in[7:0];
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         global_irq_enable_bit_r <= 1'b0;
      end
      else if (core_in.di || trap_any || (core_in.ack && irq_req_out))
      begin
         // clearing first: a taken request must never re-enter at once
         global_irq_enable_bit_r <= 1'b0;
      end
      else if (core_in.ei || core_in.return_from_handler_instr)
      begin
         global_irq_enable_bit_r <= 1'b1;
      end
      else if (apb_wr && paddr_in == pvic_pkg::OFS_CTRL)
      begin
         global_irq_enable_bit_r <= pwdata_in[pvic_pkg::CTRL_GIE_BIT];
      end
   end

   // level 0 in a field ranks the same as level 1; 1..3 ranking levels
   always_comb
   begin
      logic [1:0] best_lvl;
      logic [1:0] lvl;
      best_lvl = 2'h0;
      lvl = 2'h0;
      win_valid = 1'b0;
      win_slot = 5'h00;
      win_vec = 16'h0000;
      for (int i = 0; i < NUM_SLOT; i++)
      begin
         lvl = prio_r[2*i +: 2];
         if (lvl == 2'h0)
         begin
            lvl = 2'h1;
         end
         // strict greater keeps the earlier slot on ties
         if (pend_r[i] && enab_r[i] && (!win_valid || lvl > best_lvl))
         begin
            win_valid = 1'b1;
            best_lvl = lvl;
            win_slot = 5'(i);
            win_vec = pvic_pkg::VEC_TABLE[i];
         end
      end
      // top-level sources bypass programmable ranking
      if (illegal_instr_in)
      begin
         win_valid = 1'b1;
         win_slot = 5'h1c;
         win_vec = pvic_pkg::VEC_ILLEGAL;
      end
      if (wosc_fail_in)
      begin
         win_valid = 1'b1;
         win_slot = 5'h1d;
         win_vec = pvic_pkg::VEC_WOSC_FAIL;
      end
      if (posc_fail_in)
      begin
         win_valid = 1'b1;
         win_slot = 5'h1e;
         win_vec = pvic_pkg::VEC_POSC_FAIL;
      end
      if (wdt_req)
      begin
         win_valid = 1'b1;
         win_slot = 5'h1f;
         win_vec = pvic_pkg::VEC_WDT;
      end
   end

   // outputs registered; vector word holds high byte for even address
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         irq_req_out <= 1'b0;
         vector_addr_out <= pvic_pkg::VEC_RESET;
         vector_slot_out <= 5'h00;
         global_irq_enable_bit_out <= 1'b0;
      end
      else
      begin
         // traps are not gated by the global enable
         irq_req_out <= win_valid && (global_irq_enable_bit_r || win_slot[4:2] == 3'h7)
                        && !(core_in.ack && irq_req_out);
         vector_addr_out <= win_vec;
         vector_slot_out <= win_slot;
         global_irq_enable_bit_out <= global_irq_enable_bit_r;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         prdata_out <= 32'h0000_0000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end
      else
      begin
         // one wait state: answer one cycle into the access phase
         pready_out <= psel_in & penable_in & ~pready_out;
         pslverr_out <= psel_in & penable_in & ~pready_out & bad_addr;
         if (apb_rd && !pready_out)
         begin
            prdata_out <= rd_data;
         end
      end
   end
endmodule : pvic_ctrl

// >>> pvic_pkg.sv
// package for the prioritized vectored interrupt controller
package pvic_pkg;
   localparam int NUM_SRC = 20;
   localparam int NUM_VEC = 18;
   localparam int VEC_IDX_W = 5;
   // apb register byte offsets
   localparam logic [7:0] OFS_PEND = 8'h00;
   localparam logic [7:0] OFS_ENAB = 8'h04;
   localparam logic [7:0] OFS_PRIO = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0c;
   localparam logic [7:0] OFS_EDGE = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   // control register field
   localparam int CTRL_GIE_BIT = 0;
   localparam logic [31:0] PEND_RST = 32'h0000_0000;
   localparam logic [31:0] ENAB_RST = 32'h0000_0000;
   localparam logic [35:0] PRIO_RST = 36'h0_0000_0000;
   localparam logic [7:0] EDGE_RST = 8'h00;
   // vector slot order: slot 0 highest among maskable at equal priority level
   localparam logic [15:0] VEC_RESET = 16'h0002;
   localparam logic [15:0] VEC_WDT = 16'h0004;
   localparam logic [15:0] VEC_POSC_FAIL = 16'h003a;
   localparam logic [15:0] VEC_WOSC_FAIL = 16'h003c;
   localparam logic [15:0] VEC_ILLEGAL = 16'h0006;
   localparam logic [15:0] VEC_TABLE [NUM_VEC] = '{
      16'h000a, 16'h000c, 16'h000e, 16'h0010, 16'h0016, 16'h0018, 16'h001a,
      16'h001c, 16'h001e, 16'h0020, 16'h0022, 16'h0024, 16'h0026,
      16'h0030, 16'h0032, 16'h0034, 16'h0036, 16'h0000};
   localparam int NUM_MASKABLE = 17;
   typedef struct packed {
      logic [NUM_MASKABLE-1:0] per_src;
      logic wdt_level;
      logic posc_fail;
      logic wosc_fail;
      logic illegal;
   } pvic_events_t;
   typedef struct packed {
      logic ei;
      logic di;
      logic return_from_handler_instr;
      logic trap;
      logic ack;
   } pvic_core_t;
endpackage : pvic_pkg

// >>> pvic_properties.sv
// checker for the interrupt controller ports
`timescale 1ns/100ps
module pvic_properties (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire pvic_pkg::pvic_core_t core_in,
   input wire logic illegal_instr_in,
   input wire logic wdt_irq_enable_in,
   input wire logic psel_in,
   input wire logic irq_req_out,
   input wire logic [15:0] vector_addr_out,
   input wire logic [4:0] vector_slot_out,
   input wire logic global_irq_enable_bit_out
);
   logic g;
   assign g = global_irq_enable_bit_out;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   ei_sets_a: assert property (core_in == 5'h10 && !illegal_instr_in && !psel_in |-> ##2 g)
      else $error("enable not set");
   di_clears_a: assert property (core_in.di || core_in.trap |-> ##2 !g)
      else $error("enable not cleared");
   ack_clears_a: assert property (core_in.ack && irq_req_out |-> ##2 !g)
      else $error("ack left enable set");
   ack_drops_a: assert property (core_in.ack && irq_req_out && vector_slot_out < 5'h1c
      |-> ##2 !irq_req_out) else $error("request stayed after ack");
   vec_even_a: assert property (irq_req_out |-> !vector_addr_out[0])
      else $error("odd vector");
   reset_vec_a: assert property ($fell(rst_in) |-> vector_addr_out == 16'h0002 && !g)
      else $error("bad state after reset");
   irq_gie_a: assert property ($rose(irq_req_out) && vector_slot_out < 5'h1c |-> g)
      else $error("request while disabled");
   illegal_vec_a: assert property ($rose(illegal_instr_in) && !wdt_irq_enable_in
      |-> ##[1:3] irq_req_out && vector_addr_out == 16'h0006) else $error("no trap vector");
   last_slot_a: assert property (irq_req_out && vector_slot_out == 5'd16
      |-> vector_addr_out == 16'h0036) else $error("bad lowest vector");
   ack_c: cover property (core_in.ack && irq_req_out);
   trap_c: cover property ($rose(illegal_instr_in));
   low_c: cover property (irq_req_out && vector_slot_out == 5'd16);
endmodule : pvic_properties
bind pvic_ctrl pvic_properties props (.clk_in, .rst_in, .core_in, .illegal_instr_in,
   .wdt_irq_enable_in, .psel_in, .irq_req_out, .vector_addr_out, .vector_slot_out,
   .global_irq_enable_bit_out);

// >>> pvic_core_model.sv
// core model that acknowledges requests and records vectors
`timescale 1ns/100ps
module pvic_core_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic auto_in,
   input wire pvic_pkg::pvic_core_t cmd_in,
   input wire logic irq_in,
   input wire logic [15:0] vec_in,
   output pvic_pkg::pvic_core_t core_out,
   output logic [15:0] vec_out,
   output logic [7:0] cnt_out
);
   logic ack_r;
   logic [1:0] hold_r;
   // hold off after an ack so a stale request is never acked twice
   always_ff @(posedge clk_in)
   begin
      ack_r <= 1'b0;
      if (rst_in)
      begin
         hold_r <= 2'd0;
         cnt_out <= 8'd0;
      end
      else if (hold_r != 2'd0)
         hold_r <= hold_r - 2'd1;
      else if (irq_in && auto_in)
      begin
         ack_r <= 1'b1;
         vec_out <= vec_in;
         cnt_out <= cnt_out + 8'd1;
         hold_r <= 2'd3;
      end
   end
   assign core_out = cmd_in | {4'h0, ack_r};
endmodule : pvic_core_model

// >>> testbench.sv
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
module testbench;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, auto = 1'b0;
   logic [7:0] paddr = 8'h00, periph = 8'h00, pa = 8'h00, cnt;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, irq, gie;
   logic [3:0] pc = 4'h0;
   logic wdt = 1'b0, wdt_en = 1'b0, posc = 1'b0, wosc = 1'b0, ill = 1'b0;
   pvic_pkg::pvic_core_t cmd = '0, core;
   logic [15:0] vec, lvec;
   int mismatches = 0, cmp_count = 0, cyc = 0;
   always #5 clk_in = ~clk_in;
   pvic_ctrl dut (.clk_in, .rst_in, .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .periph_pulse_in(periph), .port_a_pin_in(pa),
      .port_c_pin_in(pc), .wdt_timeout_in(wdt), .wdt_irq_enable_in(wdt_en),
      .posc_fail_in(posc), .wosc_fail_in(wosc), .illegal_instr_in(ill), .core_in(core),
      .irq_req_out(irq), .vector_addr_out(vec), .vector_slot_out(),
      .global_irq_enable_bit_out(gie));
   pvic_core_model cpu (.clk_in, .rst_in, .auto_in(auto), .cmd_in(cmd), .irq_in(irq),
      .vec_in(vec), .core_out(core), .vec_out(lvec), .cnt_out(cnt));
   task tally_and_finish;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      pen <= 1'b1;
      @(posedge clk_in);
      while (pready !== 1'b1)
         @(posedge clk_in);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task gchk(input logic e);
      repeat (2) @(negedge clk_in);
      chk(32'(gie), 32'(e));
   endtask : gchk
   task rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rchk
   task instr(input pvic_pkg::pvic_core_t c);
      @(posedge clk_in);
      cmd <= c;
      @(posedge clk_in);
      cmd <= '0;
      @(posedge clk_in);
   endtask : instr
   task wack;
      logic [7:0] c0;
      c0 = cnt;
      while (cnt === c0)
         @(posedge clk_in);
   endtask : wack
   function automatic logic [31:0] expv(input int s);
      return 32'(s < 4 ? 10 + 2 * s : s < 13 ? 22 + 2 * (s - 4) : 48 + 2 * (s - 13));
   endfunction : expv
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         tally_and_finish;
      end
   end
   initial
   begin
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      chk(32'(vec), 32'h0002);
      rchk(pvic_pkg::OFS_CTRL, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk(32'(err), 32'h1);
      apb(1'b1, pvic_pkg::OFS_CTRL, 32'h1);
      gchk(1'b1);
      instr(5'h08);
      gchk(1'b0);
      instr(5'h10);
      gchk(1'b1);
      instr(5'h02);
      gchk(1'b0);
      instr(5'h04);
      gchk(1'b1);
      apb(1'b1, pvic_pkg::OFS_CTRL, 32'h0);
      gchk(1'b0);
      @(posedge clk_in);
      periph <= 8'hfe;
      @(posedge clk_in);
      periph <= 8'h00;
      repeat (2) @(posedge clk_in);
      rchk(pvic_pkg::OFS_PEND, 32'h7f);
      chk(32'(irq), 32'h0);
      apb(1'b1, pvic_pkg::OFS_PEND, 32'h0);
      rchk(pvic_pkg::OFS_PEND, 32'h0);
      // pa5 rising selected, pa6 left on falling
      apb(1'b1, pvic_pkg::OFS_EDGE, 32'h20);
      pa <= 8'h60;
      repeat (5) @(posedge clk_in);
      rchk(pvic_pkg::OFS_PEND, 32'h80);
      pa <= 8'h00;
      repeat (5) @(posedge clk_in);
      rchk(pvic_pkg::OFS_PEND, 32'hc0);
      pc <= 4'h1;
      repeat (5) @(posedge clk_in);
      apb(1'b1, pvic_pkg::OFS_PEND, 32'h0);
      pc <= 4'h0;
      repeat (5) @(posedge clk_in);
      rchk(pvic_pkg::OFS_PEND, 32'h10000);
      apb(1'b1, pvic_pkg::OFS_PEND, 32'h1ffff);
      apb(1'b1, pvic_pkg::OFS_ENAB, 32'h1ffff);
      auto <= 1'b1;
      for (int s = 0; s < 17; s++)
      begin
         instr(5'h10);
         wack;
         chk(32'(lvec), expv(s));
      end
      rchk(pvic_pkg::OFS_PEND, 32'h0);
      gchk(1'b0);
      apb(1'b1, 8'h28, 32'h3);
      apb(1'b1, pvic_pkg::OFS_PEND, 32'h10001);
      instr(5'h10);
      wack;
      chk(32'(lvec), 32'h0036);
      instr(5'h10);
      wack;
      chk(32'(lvec), 32'h000a);
      auto <= 1'b0;
      apb(1'b1, pvic_pkg::OFS_CTRL, 32'h1);
      ill <= 1'b1;
      repeat (4) @(posedge clk_in);
      chk(32'(vec), 32'h0006);
      gchk(1'b0);
      rchk(pvic_pkg::OFS_STAT, 32'h003c_0006);
      posc <= 1'b1;
      repeat (4) @(posedge clk_in);
      chk(32'(vec), 32'h003a);
      posc <= 1'b0;
      wosc <= 1'b1;
      repeat (4) @(posedge clk_in);
      chk(32'(vec), 32'h003c);
      wdt_en <= 1'b1;
      wdt <= 1'b1;
      repeat (6) @(posedge clk_in);
      chk(32'(vec), 32'h0004);
      {ill, wosc, wdt, wdt_en} <= 4'h0;
      repeat (6) @(posedge clk_in);
      chk(32'(irq), 32'h0);
      tally_and_finish;
   end
endmodule : testbench
